/* File: mux_regs_pkg.sv */
package mux_regs_pkg;

    // ------------------------------------------------------------------
    // register numbers (reads and writes decode them separately, 0 and 1 differ)
    // ------------------------------------------------------------------
    localparam logic [2:0] REG_IDENTITY  = 3'h0;
    localparam logic [2:0] REG_RESET     = 3'h0;
    localparam logic [2:0] REG_STATUS    = 3'h1;
    localparam logic [2:0] REG_ADDR_SEL  = 3'h1;
    localparam logic [2:0] REG_SW_STATE  = 3'h2;
    localparam logic [2:0] REG_SW_OPEN   = 3'h3;
    localparam logic [2:0] REG_RLY_OPEN  = 3'h4;
    localparam logic [2:0] REG_RLY_CLOSE = 3'h5;
    localparam logic [2:0] REG_SW_CLOSE  = 3'h6;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ST_RELAY_OPEN = 7;
    localparam int ST_NO_RIBBON  = 6;
    localparam int ST_RIBBON_CTL = 5;
    localparam int ST_NOT_SCAN   = 4;
    localparam int ST_BB_OPENING = 3;
    localparam int ST_LOCAL_OPEN = 2;
    localparam int ST_BUSY       = 1;
    localparam int ADDR_CTL_BIT  = 3;
    localparam int CMD_RELAY_BIT = 15;
    localparam logic [2:0] NO_TERMINAL = 3'h7;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] SW_STATE_RST = 8'h00;
    localparam logic [2:0] ADDR_RST     = 3'h0;
    localparam int CLK_HZ          = 10_000_000;
    localparam int SWITCH_TIME_NS  = 1000;
    localparam int SWITCH_CYCLES   = (SWITCH_TIME_NS * (CLK_HZ / 1_000_000)
                                      + 999) / 1000;
    localparam logic [7:0] SWITCH_CNT = 8'(SWITCH_CYCLES);

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_OPENING = 4'h2,
        ST_WAITBB  = 4'h4,
        ST_CLOSING = 4'h8
    } seq_t;

endpackage

/* File: mux_accessory_register_interface.sv */
// Functional notes
// - reads and writes decode registers separately
// - register 0 read gives identity byte
// - upper five component, lower three terminal
// - no terminal module forces low bits ones
// - status on lines 0-7, bit 0 zero
// - bit 7 is last relay command
// - bit 5 high under voltmeter control
// - bit 4 low during scan, busy set
// - bit 3 high while backplane opening line low
// - bit 2 high while opening a switch
// - bit 1 busy while executing or scanning
// - switch state bits 7-4 operation code
// - switch state bits 3-0 channel code
// - codes 0-3 no channel, 4-15 ch 11..0
// - register 0 write resets switches and relays
`timescale 1ns/1ps
`default_nettype none
module mux_accessory_register_interface
    import mux_regs_pkg::*;
#(
    parameter logic [4:0] COMPONENT_ID = 5'h11  // arbitrary value
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // register access
    input  wire logic        register_read_command,
    input  wire logic        register_write_command,
    input  wire logic [2:0]  reg_num,
    input  wire logic [15:0] wr_data,
    output logic      [7:0]  rd_data,
    // module straps and ribbon pins
    input  wire logic        terminal_present,
    input  wire logic [2:0]  terminal_type,
    input  wire logic        ribbon_attached_n,
    input  wire logic        scan_active,
    // backplane coordination
    input  wire logic        bp_opening_n,
    output logic             opening_pulse,
    output logic             closing_pulse,
    // switch drive
    output logic             relays_open,
    output logic      [3:0]  op_code,
    output logic      [3:0]  chan_code,
    output logic             channel_on,
    output logic      [3:0]  chan_index,
    output logic             ribbon_control,
    output logic      [2:0]  ribbon_address
);
    import mux_regs_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  sync_open;
        logic [1:0]  sync_ribbon;
        logic [1:0]  sync_scan;
        logic [7:0]  rdata;
        logic [7:0]  sw_state;
        logic        relay_open;
        logic        ribbon_ctl;
        logic [2:0]  addr;
        seq_t        seq;
        logic [7:0]  cnt;
        logic        open_p;
        logic        close_p;
        logic [3:0]  pend_op;
        logic [3:0]  pend_ch;
        logic        pend_sw;
    } state_t;

    state_t s_q;
    state_t s_d;

    // channel code 4..15 maps to channel 11..0 of the bank
    function automatic logic [3:0] chan_of(input logic [3:0] code);
        chan_of = 4'hF - code;
    endfunction

    // ------------------------------------------------------------------
    // status and identity assembly
    // ------------------------------------------------------------------
    logic [7:0] status_w;
    logic [7:0] ident_w;
    logic       busy_w;
    logic       bb_open_w;

    always_comb begin
        bb_open_w = ~s_q.sync_open[1];
        busy_w    = (s_q.seq != ST_IDLE) | s_q.sync_scan[1];
        ident_w   = {COMPONENT_ID,
                     terminal_present ? terminal_type : NO_TERMINAL};
        status_w  = 8'h00;
        status_w[ST_RELAY_OPEN] = s_q.relay_open;
        status_w[ST_NO_RIBBON]  = s_q.sync_ribbon[1];
        status_w[ST_RIBBON_CTL] = s_q.ribbon_ctl;
        status_w[ST_NOT_SCAN]   = ~s_q.sync_scan[1];
        status_w[ST_BB_OPENING] = bb_open_w;
        status_w[ST_LOCAL_OPEN] = (s_q.seq == ST_OPENING);
        status_w[ST_BUSY]       = busy_w;
    end

    // ------------------------------------------------------------------
    // next state: register decode and switching sequence
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.sync_open   = {s_q.sync_open[0], bp_opening_n};
        s_d.sync_ribbon = {s_q.sync_ribbon[0], ribbon_attached_n};
        s_d.sync_scan   = {s_q.sync_scan[0], scan_active};
        s_d.open_p  = 1'b0;
        s_d.close_p = 1'b0;

        // reads only load the data register, nothing else moves
        if (register_read_command) begin
            unique case (reg_num)
                REG_IDENTITY: s_d.rdata = ident_w;
                REG_STATUS:   s_d.rdata = status_w;
                REG_SW_STATE: s_d.rdata = s_q.sw_state;
                default:      s_d.rdata = 8'h00;
            endcase
        end

        // sequence advance
        unique case (s_q.seq)
            ST_IDLE: ;
            ST_OPENING: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.seq = ST_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            ST_WAITBB: begin
                // closure waits until backplane opening line goes high
                if (!bb_open_w) begin
                    s_d.seq     = ST_CLOSING;
                    s_d.cnt     = SWITCH_CNT;
                    s_d.close_p = 1'b1;
                    if (s_q.pend_sw) begin
                        s_d.sw_state = {s_q.pend_op, s_q.pend_ch};
                    end else begin
                        s_d.relay_open = 1'b0;
                    end
                end
            end
            ST_CLOSING: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.seq = ST_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            default: s_d.seq = ST_IDLE;
        endcase

        if (register_write_command) begin
            unique case (reg_num)
                REG_RESET: begin
                    s_d.sw_state   = SW_STATE_RST;
                    s_d.relay_open = 1'b1;
                    s_d.seq        = ST_IDLE;
                    s_d.cnt        = 8'h00;
                    s_d.open_p     = 1'b0;
                    s_d.close_p    = 1'b0;
                end
                REG_ADDR_SEL: begin
                    s_d.ribbon_ctl = wr_data[ADDR_CTL_BIT];
                    s_d.addr       = wr_data[2:0];
                end
                REG_SW_OPEN, REG_RLY_OPEN: begin
                    s_d.seq    = ST_OPENING;
                    s_d.cnt    = SWITCH_CNT;
                    s_d.open_p = 1'b1;
                    if (reg_num == REG_RLY_OPEN ||
                        wr_data[CMD_RELAY_BIT]) begin
                        s_d.relay_open = 1'b1;
                    end
                    if (reg_num == REG_SW_OPEN &&
                        wr_data[7:0] == s_q.sw_state) begin
                        s_d.sw_state = SW_STATE_RST;
                    end
                end
                REG_RLY_CLOSE, REG_SW_CLOSE: begin
                    s_d.seq     = ST_WAITBB;
                    s_d.pend_sw = (reg_num == REG_SW_CLOSE);
                    s_d.pend_op = wr_data[7:4];
                    s_d.pend_ch = wr_data[3:0];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{sync_open: 2'b11, sync_ribbon: 2'b11, sync_scan: 2'b00,
                     rdata: 8'h00, sw_state: SW_STATE_RST, relay_open: 1'b1,
                     ribbon_ctl: 1'b0, addr: ADDR_RST, seq: ST_IDLE,
                     cnt: 8'h00, open_p: 1'b0, close_p: 1'b0,
                     pend_op: 4'h0, pend_ch: 4'h0, pend_sw: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rd_data        = s_q.rdata;
    assign opening_pulse  = s_q.open_p;
    assign closing_pulse  = s_q.close_p;
    assign relays_open    = s_q.relay_open;
    assign op_code        = s_q.sw_state[7:4];
    assign chan_code      = s_q.sw_state[3:0];
    assign channel_on     = s_q.sw_state[3:2] != 2'b00;
    assign chan_index     = channel_on ? chan_of(s_q.sw_state[3:0]) : 4'h0;
    assign ribbon_control = s_q.ribbon_ctl;
    assign ribbon_address = s_q.addr;

endmodule
`default_nettype wire

/* File: mux_accessory_register_interface_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module mux_accessory_register_interface_assertions
    import mux_regs_pkg::*;
(
    // clock, reset and register access
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       register_read_command,
    input wire logic       register_write_command,
    input wire logic [2:0] reg_num,
    input wire logic [7:0] rd_data,
    // straps and outputs
    input wire logic       terminal_present,
    input wire logic [2:0] terminal_type,
    input wire logic       bp_opening_n,
    input wire logic       opening_pulse,
    input wire logic       closing_pulse,
    input wire logic       relays_open,
    input wire logic [3:0] op_code,
    input wire logic [3:0] chan_code,
    input wire logic       channel_on,
    input wire logic [3:0] chan_index
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // request shapes shared by the properties
    sequence rd_of(logic [2:0] n);
        register_read_command && reg_num == n;
    endsequence
    sequence wr_of(logic [2:0] n);
        register_write_command && reg_num == n;
    endsequence
    sequence close_req;
        wr_of(REG_SW_CLOSE) ##0 bp_opening_n;
    endsequence
    chk_ident_low: assert property (rd_of(REG_IDENTITY) |=>
        rd_data[2:0] == ($past(terminal_present) ? $past(terminal_type)
                                                 : NO_TERMINAL))
        else $error("identity low bits wrong");
    chk_status_zero: assert property (rd_of(REG_STATUS) |=> !rd_data[0])
        else $error("status bit 0 not low");
    chk_unused_read: assert property (
        register_read_command && reg_num > 3'h2 |=> rd_data == 8'h00)
        else $error("unused register read not zero");
    chk_read_hold: assert property (
        !register_read_command |=> $stable(rd_data))
        else $error("read data changed without a read");
    chk_reset_write: assert property (wr_of(REG_RESET) |=>
        relays_open && op_code == 4'h0 && chan_code == 4'h0)
        else $error("reset write left switches closed");
    chk_relay_open: assert property (
        wr_of(REG_RLY_OPEN) |=> relays_open && opening_pulse)
        else $error("relay open write not obeyed");
    chk_open_cause: assert property (opening_pulse |->
        $past(register_write_command) && ($past(reg_num) == REG_SW_OPEN
        || $past(reg_num) == REG_RLY_OPEN))
        else $error("opening pulse without open write");
    chk_close_pulse: assert property (
        close_req |-> ##[1:4] closing_pulse)
        else $error("close write gave no closing pulse");
    chk_chan_decode: assert property (
        channel_on == (chan_code > 4'h3) &&
        chan_index == (channel_on ? 4'hF - chan_code : 4'h0))
        else $error("channel decode wrong");
endmodule
bind mux_accessory_register_interface
    mux_accessory_register_interface_assertions chk_i (.clk, .nrst,
    .register_read_command, .register_write_command, .reg_num, .rd_data,
    .terminal_present, .terminal_type, .bp_opening_n, .opening_pulse,
    .closing_pulse, .relays_open, .op_code, .chan_code, .channel_on,
    .chan_index);
`default_nettype wire

/* File: mux_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mux_host_model
    import mux_regs_pkg::*;
(
    // clock
    input  wire logic        clk,
    // register access toward the block
    output logic             register_read_command,
    output logic             register_write_command,
    output logic      [2:0]  reg_num,
    output logic      [15:0] wr_data
);
    initial begin
        register_read_command  = 1'b0;
        register_write_command = 1'b0;
        reg_num                = 3'h0;
        wr_data                = 16'h0000;
    end
    // one-cycle command; busy time is waited out before any write
    task automatic access(input logic w, input logic [2:0] n,
                          input logic [15:0] d);
        if (w) repeat (2 * SWITCH_CYCLES + 8) @(posedge clk);
        @(posedge clk);
        register_read_command  <= !w;
        register_write_command <= w;
        reg_num                <= n;
        wr_data                <= d;
        @(posedge clk);
        register_read_command  <= 1'b0;
        register_write_command <= 1'b0;
        wr_data                <= ~d; // stale data must not look valid
    endtask
endmodule
`default_nettype wire

/* File: mux_accessory_register_interface_test.sv */
`timescale 1ns/1ps
`default_nettype none
module mux_accessory_register_interface_test;
    import mux_regs_pkg::*;
    localparam logic [4:0] CID = 5'h0A; // arbitrary value
    // relay bit settles 1 ms after close, 0.5 ms after open (100 ns clk)
    localparam int RLY_CLOSE_WAIT = 10000;
    localparam int RLY_OPEN_WAIT  = 5000;
    logic clk = 1'b0, nrst = 1'b0, pend = 1'b0, rly = 1'b1;
    logic register_read_command, register_write_command;
    logic terminal_present, ribbon_attached_n, scan_active, bp_opening_n;
    logic opening_pulse, closing_pulse, relays_open, channel_on;
    logic ribbon_control;
    logic [2:0] reg_num, terminal_type, ribbon_address;
    logic [3:0] op_code, chan_code, chan_index;
    logic [7:0] rd_data;
    logic [15:0] wr_data, d;
    logic [7:0] exp_q[$];
    int mismatches = 0, samples_checked = 0, cycles = 0, seed = 60445;
    always #50 clk = ~clk;
    mux_host_model mux_host_model_i (.clk, .register_read_command,
        .register_write_command, .reg_num, .wr_data);
    mux_accessory_register_interface #(.COMPONENT_ID(CID))
        mux_accessory_register_interface_i (.clk, .nrst,
        .register_read_command, .register_write_command, .reg_num,
        .wr_data, .rd_data, .terminal_present, .terminal_type,
        .ribbon_attached_n, .scan_active, .bp_opening_n, .opening_pulse,
        .closing_pulse, .relays_open, .op_code, .chan_code, .channel_on,
        .chan_index, .ribbon_control, .ribbon_address);
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // note the expected byte first, the monitor pairs it with rd_data
    task automatic rd(input logic [2:0] n, input logic [7:0] want);
        exp_q.push_back(want);
        mux_host_model_i.access(1'b0, n, 16'h0000);
    endtask
    task automatic wr(input logic [2:0] n, input logic [15:0] v);
        mux_host_model_i.access(1'b1, n, v);
        repeat (30) @(posedge clk);
    endtask
    function automatic logic [7:0] status(input logic ctl);
        return {rly, 1'b1, ctl, 1'b1, 4'h0};
    endfunction
    // monitor: a read taken at one edge is answered by the next
    always @(posedge clk) begin
        if (pend) check(rd_data, exp_q.pop_front());
        pend = register_read_command;
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        {terminal_present, terminal_type, scan_active} = 5'h00;
        {ribbon_attached_n, bp_opening_n} = 2'h3;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        // host sees the byte as a negative decimal, same eight bits
        rd(REG_IDENTITY, 8'(int'({CID, NO_TERMINAL}) - 256));
        d = 16'($random(seed));
        terminal_present <= 1'b1;
        terminal_type <= d[2:0];
        rd(REG_IDENTITY, {CID, d[2:0]});
        for (int n = 3; n < 8; n++) rd(3'(n), 8'h00);
        rd(REG_STATUS, status(1'b0));
        {ribbon_attached_n, scan_active, bp_opening_n} <= 3'h2;
        repeat (4) @(posedge clk);
        rd(REG_STATUS, 8'h8A);
        {ribbon_attached_n, scan_active, bp_opening_n} <= 3'h5;
        repeat (4) @(posedge clk);
        mux_host_model_i.access(1'b1, REG_ADDR_SEL, 16'h000D);
        @(negedge clk) check({4'h0, ribbon_control, ribbon_address}, 8'h0D);
        rd(REG_STATUS, status(1'b1));
        wr(REG_ADDR_SEL, 16'h0000);
        wr(REG_RLY_CLOSE, 16'h0000);
        repeat (RLY_CLOSE_WAIT) @(posedge clk);
        rly = 1'b0;
        rd(REG_STATUS, status(1'b0));
        for (int i = 0; i < 4; i++) begin
            d = 16'($random(seed));
            wr(REG_SW_CLOSE, d);
            rd(REG_SW_STATE, d[7:0]);
            rd(REG_SW_STATE, d[7:0]);
            check({op_code, chan_code}, d[7:0]);
            check({3'h0, channel_on, chan_index},
                  (d[3:2] != 2'b00) ? {4'h1, 4'hF - d[3:0]} : 8'h00);
        end
        // relay bit cleared: this open must leave the relays alone
        mux_host_model_i.access(1'b1, REG_SW_OPEN, {1'b0, d[14:0]});
        @(negedge clk) check({7'h0, opening_pulse}, 8'h01);
        rd(REG_STATUS, status(1'b0) | 8'h06);
        repeat (30) @(posedge clk);
        rd(REG_SW_STATE, 8'h00);
        wr(REG_RLY_OPEN, 16'h0000);
        repeat (RLY_OPEN_WAIT) @(posedge clk);
        rly = 1'b1;
        rd(REG_STATUS, status(1'b0));
        wr(REG_RLY_CLOSE, 16'h0000);
        wr(REG_SW_CLOSE, 16'h002F);
        wr(REG_RESET, 16'h00A5);
        @(negedge clk) check({7'h0, relays_open}, 8'h01);
        rd(REG_SW_STATE, 8'h00);
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule
`default_nettype wire
